// *** hdl/lsc_pkg.sv ***
// Shared constants, register map and helper functions of the light sensor conversion control
package lsc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam int unsigned CONV_SHORT_MS = 100;
  localparam int unsigned CONV_LONG_MS = 800;
  localparam int unsigned CONV_SHORT_CYC = CONV_SHORT_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned CONV_LONG_CYC = CONV_LONG_MS * (SYS_CLK_HZ / 1000);
  localparam int CNT_W = 25;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_RESULT = 8'h04;
  localparam logic [7:0] ADDR_HI_LIM = 8'h08;
  localparam logic [7:0] ADDR_LO_LIM = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------
  localparam int CFG_RANGE_LSB = 12;
  localparam int CFG_TIME_BIT = 11;
  localparam int CFG_MODE_LSB = 9;
  localparam int CFG_OVF_BIT = 8;
  localparam int CFG_CRF_BIT = 7;
  localparam int CFG_FH_BIT = 6;
  localparam int CFG_FL_BIT = 5;
  localparam int CFG_LATCH_BIT = 4;
  localparam int CFG_POL_BIT = 3;
  localparam int CFG_ME_BIT = 2;
  localparam int CFG_FC_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] RANGE_RST = 4'hC;
  localparam logic TIME_RST = 1'b1;
  localparam logic LATCH_RST = 1'b1;
  localparam logic POL_RST = 1'b0;
  localparam logic ME_RST = 1'b0;
  localparam logic [1:0] FC_RST = 2'b00;
  localparam logic [15:0] HI_LIM_RST = 16'hBFFF;
  localparam logic [15:0] LO_LIM_RST = 16'h0000;
  localparam logic [1:0] MODE_SHUTDOWN = 2'b00;
  localparam logic [1:0] MODE_ONESHOT = 2'b01;
  localparam logic [3:0] RANGE_AUTO = 4'hC;
  localparam logic [3:0] RANGE_MAX = 4'hB;

  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_HIGH = 1;
  localparam int IRQ_LOW = 2;
  localparam int IRQ_OVF = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Exponent/mantissa code to a linear value for limit comparison
  function automatic logic [26:0] lux_value(input logic [15:0] code);
    return 27'(code[11:0]) << code[15:12];
  endfunction

  // Consecutive fault events needed: 1, 2, 4 or 8
  function automatic logic [3:0] fault_need(input logic [1:0] fc);
    return 4'h1 << fc;
  endfunction

endpackage

// *** hdl/lsc_sync.sv ***
// Three-stage input synchroniser with agreement filter for front-end signals
`timescale 1ns/1ps
`default_nettype none
module lsc_sync #(
  parameter int W = 13
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A bit changes only once the second and third stages agree
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // lsc_sync
`default_nettype wire

// *** hdl/lsc_conv_seq.sv ***
// Conversion sequencer: integration timing, one-shot end and automatic range stepping
`timescale 1ns/1ps
`default_nettype none
module lsc_conv_seq import lsc_pkg::*; #(
  parameter int unsigned SHORT_CYC = CONV_SHORT_CYC,
  parameter int unsigned LONG_CYC = CONV_LONG_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] mode,
  input wire logic long_time,
  input wire logic [3:0] range_sel,
  input wire logic overload,
  output logic busy,
  output logic done,
  output logic done_ovf,
  output logic [3:0] cur_range
);
  typedef enum logic {SEQ_IDLE, SEQ_CONV} lsc_seq_e;
  lsc_seq_e state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic ovl_seen_reg;
  logic auto_mode;
  logic at_end;

  assign auto_mode = (range_sel == RANGE_AUTO);
  assign at_end = (cnt_reg == (long_time ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1)));
  assign busy = (state_reg == SEQ_CONV);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= SEQ_IDLE;
      cnt_reg <= '0;
      ovl_seen_reg <= 1'b0;
      cur_range <= '0;
      done <= 1'b0;
      done_ovf <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_reg)
        SEQ_IDLE: begin
          // Held off while the one-shot mode is still being cleared
          if (mode != MODE_SHUTDOWN && !done) begin
            state_reg <= SEQ_CONV;
            cnt_reg <= '0;
            ovl_seen_reg <= 1'b0;
            // Reserved range codes run at the top manual range
            cur_range <= auto_mode ? 4'h0 : (range_sel > RANGE_MAX ? RANGE_MAX : range_sel);
          end
        end
        SEQ_CONV: begin
          if (mode == MODE_SHUTDOWN) begin
            state_reg <= SEQ_IDLE;
          end else if (auto_mode && overload && cur_range < RANGE_MAX) begin
            cur_range <= cur_range + 4'h1;
            cnt_reg <= '0;
            ovl_seen_reg <= 1'b0;
          end else if (at_end) begin
            done <= 1'b1;
            done_ovf <= ovl_seen_reg | overload;
            cnt_reg <= '0;
            ovl_seen_reg <= 1'b0;
            // Continuous codes restart at once; one-shot returns to idle
            if (mode == MODE_ONESHOT) begin
              state_reg <= SEQ_IDLE;
            end else if (auto_mode) begin
              cur_range <= 4'h0;
            end
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
            if (overload) begin
              ovl_seen_reg <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_auto_step;
    busy && mode != MODE_SHUTDOWN && auto_mode && overload && cur_range < RANGE_MAX
      |=> cur_range == $past(cur_range) + 4'h1 && !done;
  endproperty
  a_auto_step: assert property (p_auto_step) else $error("auto range did not step up");

  property p_oneshot_idle;
    done && $past(mode) == MODE_ONESHOT |-> state_reg == SEQ_IDLE;
  endproperty
  a_oneshot_idle: assert property (p_oneshot_idle) else $error("one-shot did not stop");
endmodule // lsc_conv_seq
`default_nettype wire

// *** hdl/lsc_top.sv ***
// Light sensor conversion control: register file, flags and interrupt over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module lsc_top import lsc_pkg::*; #(
  parameter int unsigned SHORT_CYC = CONV_SHORT_CYC,
  parameter int unsigned LONG_CYC = CONV_LONG_CYC
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [11:0] ADC_MANTISSA,
  input wire logic ADC_OVERLOAD,
  output logic IRQ
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0] range_select_field;
  logic time_reg;
  logic [1:0] mode_reg;
  logic range_overload_flag;
  logic conversion_done_flag;
  logic above_limit_flag;
  logic below_limit_flag;
  logic latch_reg;
  logic pol_reg;
  logic me_reg;
  logic [1:0] consecutive_fault_field;
  logic [15:0] result_reg;
  logic [15:0] hi_lim_reg;
  logic [15:0] lo_lim_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [3:0] hi_run_reg;
  logic [3:0] lo_run_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [12:0] fe_sync;
  logic seq_busy;
  logic seq_done;
  logic seq_ovf;
  logic [3:0] seq_range;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic cfg_wr;
  logic cfg_rd;
  logic stat_rd;
  logic [15:0] cfg_word;
  logic [15:0] cfg_merged;
  logic [15:0] new_result;
  logic [26:0] new_value;
  logic new_above;
  logic new_below;
  logic [3:0] need;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // Front end and sequencer
  // ----------------------------------------------------------------
  lsc_sync #(.W(13)) u_sync (
    .clk(SYS_CLK),
    .srst(SRST),
    .async_in({ADC_OVERLOAD, ADC_MANTISSA}),
    .sync_out(fe_sync)
  );

  lsc_conv_seq #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_seq (
    .clk(SYS_CLK),
    .srst(SRST),
    .mode(mode_reg),
    .long_time(time_reg),
    .range_sel(range_select_field),
    .overload(fe_sync[12]),
    .busy(seq_busy),
    .done(seq_done),
    .done_ovf(seq_ovf),
    .cur_range(seq_range)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  assign aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_hs = S_AXI_WVALID & S_AXI_WREADY;
  assign ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
  assign do_write = aw_full_reg & w_full_reg & ~S_AXI_BVALID;
  assign cfg_wr = do_write && aw_addr_reg == ADDR_CFG;
  assign cfg_rd = ar_hs && S_AXI_ARADDR == ADDR_CFG;
  assign stat_rd = ar_hs && S_AXI_ARADDR == ADDR_IRQ_STAT;
  assign cfg_merged = merge16(cfg_word, w_data_reg, w_strb_reg);
  assign cfg_word = {range_select_field, time_reg, mode_reg, range_overload_flag,
                     conversion_done_flag, above_limit_flag, below_limit_flag,
                     latch_reg, pol_reg, me_reg, consecutive_fault_field};

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      S_AXI_AWREADY <= 1'b0;
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (aw_hs) begin
      S_AXI_AWREADY <= 1'b0;
      aw_full_reg <= 1'b1;
      aw_addr_reg <= S_AXI_AWADDR;
    end else begin
      if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      S_AXI_AWREADY <= ~aw_full_reg & ~S_AXI_BVALID;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      S_AXI_WREADY <= 1'b0;
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (w_hs) begin
      S_AXI_WREADY <= 1'b0;
      w_full_reg <= 1'b1;
      w_data_reg <= S_AXI_WDATA;
      w_strb_reg <= S_AXI_WSTRB;
    end else begin
      if (do_write) begin
        w_full_reg <= 1'b0;
      end
      S_AXI_WREADY <= ~w_full_reg & ~S_AXI_BVALID;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (aw_addr_reg == ADDR_CFG || aw_addr_reg == ADDR_HI_LIM ||
                      aw_addr_reg == ADDR_LO_LIM || aw_addr_reg == ADDR_IRQ_MASK ||
                      aw_addr_reg == ADDR_RESULT || aw_addr_reg == ADDR_IRQ_STAT)
                     ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (ar_hs) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= RESP_OKAY;
      unique case (S_AXI_ARADDR)
        ADDR_CFG: S_AXI_RDATA <= {16'h0000, cfg_word};
        ADDR_RESULT: S_AXI_RDATA <= {16'h0000, result_reg};
        ADDR_HI_LIM: S_AXI_RDATA <= {16'h0000, hi_lim_reg};
        ADDR_LO_LIM: S_AXI_RDATA <= {16'h0000, lo_lim_reg};
        ADDR_IRQ_STAT: S_AXI_RDATA <= {28'h000_0000, irq_stat_reg};
        ADDR_IRQ_MASK: S_AXI_RDATA <= {28'h000_0000, irq_mask_reg};
        default: begin
          S_AXI_RDATA <= '0;
          S_AXI_RRESP <= RESP_SLVERR;
        end
      endcase
    end else begin
      if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
      S_AXI_ARREADY <= ~S_AXI_RVALID | S_AXI_RREADY;
    end
  end

  // ----------------------------------------------------------------
  // Host-writable fields
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      range_select_field <= RANGE_RST;
      time_reg <= TIME_RST;
      mode_reg <= MODE_SHUTDOWN;
      latch_reg <= LATCH_RST;
      pol_reg <= POL_RST;
      me_reg <= ME_RST;
      consecutive_fault_field <= FC_RST;
    end else if (cfg_wr) begin
      // Status bits of the merged word are dropped here
      range_select_field <= cfg_merged[CFG_RANGE_LSB +: 4];
      time_reg <= cfg_merged[CFG_TIME_BIT];
      mode_reg <= cfg_merged[CFG_MODE_LSB +: 2];
      latch_reg <= cfg_merged[CFG_LATCH_BIT];
      pol_reg <= cfg_merged[CFG_POL_BIT];
      me_reg <= cfg_merged[CFG_ME_BIT];
      consecutive_fault_field <= cfg_merged[CFG_FC_LSB +: 2];
    end else if (seq_done && mode_reg == MODE_ONESHOT) begin
      mode_reg <= MODE_SHUTDOWN;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      hi_lim_reg <= HI_LIM_RST;
      lo_lim_reg <= LO_LIM_RST;
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (do_write) begin
      if (aw_addr_reg == ADDR_HI_LIM) begin
        hi_lim_reg <= merge16(hi_lim_reg, w_data_reg, w_strb_reg);
      end
      if (aw_addr_reg == ADDR_LO_LIM) begin
        lo_lim_reg <= merge16(lo_lim_reg, w_data_reg, w_strb_reg);
      end
      if (aw_addr_reg == ADDR_IRQ_MASK && w_strb_reg[0]) begin
        irq_mask_reg <= w_data_reg[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Measurement result and status flags
  // ----------------------------------------------------------------
  assign new_result = {seq_range, fe_sync[11:0]};
  assign new_value = lux_value(new_result);
  assign new_above = new_value > lux_value(hi_lim_reg);
  assign new_below = new_value < lux_value(lo_lim_reg);
  assign need = fault_need(consecutive_fault_field);

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      result_reg <= '0;
      range_overload_flag <= 1'b0;
    end else if (seq_done) begin
      result_reg <= new_result;
      range_overload_flag <= seq_ovf;
    end
  end

  // Shutdown never touches these flags, so they stay readable while idle
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      conversion_done_flag <= 1'b0;
    end else if (seq_done) begin
      conversion_done_flag <= 1'b1;
    end else if (cfg_rd || (cfg_wr && cfg_merged[CFG_MODE_LSB +: 2] != MODE_SHUTDOWN)) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // Latched style clears on a config read; transparent style on a quiet result
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      hi_run_reg <= '0;
      above_limit_flag <= 1'b0;
    end else if (seq_done && new_above) begin
      hi_run_reg <= (hi_run_reg == 4'h8) ? 4'h8 : hi_run_reg + 4'h1;
      if (hi_run_reg + 4'h1 >= need) begin
        above_limit_flag <= 1'b1;
      end
    end else if (seq_done) begin
      hi_run_reg <= '0;
      if (!latch_reg) begin
        above_limit_flag <= 1'b0;
      end
    end else if (cfg_rd && latch_reg) begin
      above_limit_flag <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      lo_run_reg <= '0;
      below_limit_flag <= 1'b0;
    end else if (seq_done && new_below) begin
      lo_run_reg <= (lo_run_reg == 4'h8) ? 4'h8 : lo_run_reg + 4'h1;
      if (lo_run_reg + 4'h1 >= need) begin
        below_limit_flag <= 1'b1;
      end
    end else if (seq_done) begin
      lo_run_reg <= '0;
      if (!latch_reg) begin
        below_limit_flag <= 1'b0;
      end
    end else if (cfg_rd && latch_reg) begin
      below_limit_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status: set wins over the clearing read
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (stat_rd ? '0 : irq_stat_reg) |
                      {seq_done & seq_ovf,
                       seq_done & new_below & (lo_run_reg + 4'h1 >= need),
                       seq_done & new_above & (hi_run_reg + 4'h1 >= need),
                       seq_done};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  sequence s_oneshot_end;
    seq_done && mode_reg == MODE_ONESHOT && !cfg_wr;
  endsequence

  property p_mode_reset;
    $past(SRST) |-> mode_reg == MODE_SHUTDOWN;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode not shutdown after reset");

  property p_oneshot_off;
    s_oneshot_end |=> mode_reg == MODE_SHUTDOWN ##1 !seq_busy;
  endproperty
  a_oneshot_off: assert property (p_oneshot_off) else $error("one-shot did not shut down");

  property p_oneshot_hold;
    seq_busy && mode_reg == MODE_ONESHOT && !seq_done && !cfg_wr |=> mode_reg == MODE_ONESHOT;
  endproperty
  a_oneshot_hold: assert property (p_oneshot_hold) else $error("one-shot mode lost early");

  property p_ready_set;
    seq_done |=> conversion_done_flag && irq_stat_reg[IRQ_DONE];
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready flag not set");

  property p_ready_read_clr;
    cfg_rd && !seq_done |=> !conversion_done_flag;
  endproperty
  a_ready_read_clr: assert property (p_ready_read_clr) else $error("ready not cleared");

  property p_ready_sd_keep;
    conversion_done_flag && cfg_wr && !cfg_rd && cfg_merged[CFG_MODE_LSB +: 2] == MODE_SHUTDOWN
      |=> conversion_done_flag;
  endproperty
  a_ready_sd_keep: assert property (p_ready_sd_keep) else $error("shutdown write hit ready");

  property p_ovf_update;
    seq_done |=> range_overload_flag == $past(seq_ovf);
  endproperty
  a_ovf_update: assert property (p_ovf_update) else $error("overflow flag not updated");

  property p_status_ro;
    !seq_done |=> $stable(range_overload_flag) && $stable(result_reg);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed without result");

  property p_high_one;
    seq_done && new_above && consecutive_fault_field == 2'b00 |=> above_limit_flag;
  endproperty
  a_high_one: assert property (p_high_one) else $error("high flag missed");

  property p_irq_level;
    |(irq_stat_reg & irq_mask_reg) |=> IRQ;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");
endmodule // lsc_top
`default_nettype wire

// *** dv/lsc_host.sv ***
// Register-bus host model: AXI4-Lite master tasks
`timescale 1ns/1ps
`default_nettype none
module lsc_host (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic hang
);
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, hang} = '0;
  // Valid drops only at the edge that took it; a stuck slave raises hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hF, 3'b111};
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    r = bresp;
    if (!bvalid) hang <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    {d, r} = {rdata, rresp};
    if (!rvalid) hang <= 1'b1;
  endtask
endmodule // lsc_host
`default_nettype wire

// *** dv/test_light_sensor_conversion_control.sv ***
// Self-checking bench of the light sensor conversion control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module test_light_sensor_conversion_control;
  logic clk = 0, srst = 1, ovl = 0, awv, awr, wv, wrr, bv, br, arv, arr, rv, rr, irq, hang;
  logic [11:0] mant = 12'h123;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, rdv;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, rs;
  int error_cnt = 0, n_checks = 0;
  // Rows: write, address, data, response, read data
  localparam logic [74:0] ROWS [7] = '{
    {1'b0, 8'h00, 32'h0, 2'b00, 32'h0000_C810},
    {1'b1, 8'h00, 32'h0000_C9E0, 2'b00, 32'h0},
    {1'b0, 8'h00, 32'h0, 2'b00, 32'h0000_C800},
    {1'b1, 8'h18, 32'h1, 2'b10, 32'h0},
    {1'b0, 8'h18, 32'h0, 2'b10, 32'h0},
    {1'b1, 8'h14, 32'h1, 2'b00, 32'h0},
    {1'b0, 8'h14, 32'h0, 2'b00, 32'h1}};
  lsc_top #(.SHORT_CYC(20), .LONG_CYC(40)) lsc_top_i (.SYS_CLK(clk), .SRST(srst),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr), .ADC_MANTISSA(mant), .ADC_OVERLOAD(ovl), .IRQ(irq));
  lsc_host lsc_host_i (.clk(clk), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd),
    .wstrb(ws), .wvalid(wv), .wready(wrr), .bresp(bresp), .bvalid(bv), .bready(br),
    .araddr(ara), .arvalid(arv), .arready(arr), .rdata(rdat), .rresp(rresp), .rvalid(rv),
    .rready(rr), .hang(hang));
  initial forever #12.5 clk = ~clk;
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge hang) begin
    error_cnt++;
    conclude();
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    lsc_host_i.wr(a, d, rs);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    lsc_host_i.rd(a, rdv, rs);
    `CHK("rdata", e, rdv)
  endtask
  // Bounded wait for the interrupt line; the first edges let a level cleared by a read drop
  task automatic wirq;
    int n = 0;
    repeat (2) @(posedge clk);
    while (irq !== 1'b1) begin
      @(posedge clk);
      if (++n > 300) begin
        error_cnt++;
        conclude();
      end
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i][74]) lsc_host_i.wr(ROWS[i][73:66], ROWS[i][65:34], rs);
      else lsc_host_i.rd(ROWS[i][73:66], rdv, rs);
      `CHK("resp", ROWS[i][33:32], rs)
      if (!ROWS[i][74]) `CHK("rdata", ROWS[i][31:0], rdv)
    end
    wr(8'h00, 32'h0000_0210);
    rdc(8'h00, 32'h0000_0210);
    wirq();
    rdc(8'h00, 32'h0000_0090);
    rdc(8'h00, 32'h0000_0010);
    `CHK("irq", 1'b1, irq)
    rdc(8'h10, 32'h0000_0001);
    ovl <= 1'b1;
    wr(8'h00, 32'h0000_C210);
    wirq();
    wr(8'h00, 32'h0000_C010);
    rdc(8'h00, 32'h0000_C190);
    rdc(8'h04, 32'h0000_B123);
    rdc(8'h10, 32'h0000_0009);
    ovl <= 1'b0;
    wr(8'h08, 32'h0000_0100);
    for (int fc = 0; fc < 4; fc++) begin
      mant <= 12'h050;
      wr(8'h00, 32'(1024 + 512 * (fc % 2) + fc));
      wirq();
      rdc(8'h10, 32'h0000_0001);
      mant <= 12'h123;
      for (int k = 1; k <= (1 << fc); k++) begin
        wirq();
        rdc(8'h10, (k == (1 << fc)) ? 32'h0000_0003 : 32'h0000_0001);
      end
      wr(8'h00, 32'h0);
    end
    // Short overload spike on a manual range, result between the limits inverted
    wr(8'h0C, 32'h0000_0200);
    wr(8'h00, 32'h0000_0210);
    ovl <= 1'b1;
    repeat (6) @(posedge clk);
    ovl <= 1'b0;
    wirq();
    rdc(8'h00, 32'h0000_01F0);
    rdc(8'h04, 32'h0000_0123);
    rdc(8'h10, 32'h0000_000F);
    // Reset in the middle of a continuous conversion
    wr(8'h00, 32'h0000_0410);
    repeat (5) @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rdc(8'h00, 32'h0000_C810);
    conclude();
  end
endmodule // test_light_sensor_conversion_control
`default_nettype wire
